// ===== logic/fsl_pkg.sv
// Shared constants and types for the flash sector lock host controller.
package fsl_pkg;

	// ----------------------------------------------------------------
	// Clock and timing
	// ----------------------------------------------------------------
	localparam int unsigned CLK_PERIOD_NS = 5;
	localparam int unsigned T_VSL_US = 20;
	localparam int unsigned T_PUW_MS = 5;
	localparam int unsigned T_RST_US = 30;
	// Least times, so every count rounds up.
	localparam int unsigned VSL_CYC = (T_VSL_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int unsigned PUW_CYC_DEF = (T_PUW_MS * 1000000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int unsigned RST_CYC_DEF = (T_RST_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	// Half of the serial clock period in system clocks, giving a 50 ns serial clock.
	localparam logic [3:0] SCLK_HALF_CYC = 4'h5;

	// ----------------------------------------------------------------
	// Instruction opcodes and frame lengths
	// ----------------------------------------------------------------
	localparam logic [7:0] OP_LOCK = 8'h36;
	localparam logic [7:0] OP_UNLOCK = 8'h39;
	localparam logic [7:0] OP_RD_LOCK = 8'h3d;
	localparam logic [7:0] OP_GLOBAL_LOCK = 8'h7e;
	localparam logic [7:0] OP_GLOBAL_UNLOCK = 8'h98;
	localparam logic [7:0] OP_RESET_EN = 8'h66;
	localparam logic [7:0] OP_RESET = 8'h99;
	localparam logic [5:0] BITS_OPCODE = 6'h08;
	localparam logic [5:0] BITS_OP_ADDR = 6'h20;
	localparam logic [5:0] BITS_RD_LOCK = 6'h28;
	localparam logic [5:0] BITS_LAST = 6'h01;

	// ----------------------------------------------------------------
	// Own register map and fields
	// ----------------------------------------------------------------
	localparam int unsigned AXI_AW = 8;
	localparam logic [7:0] REG_CMD = 8'h00;
	localparam logic [7:0] REG_ADDR = 8'h04;
	localparam logic [7:0] REG_STATUS = 8'h08;
	localparam logic [7:0] REG_WREN_OP = 8'h0c;
	localparam logic [7:0] REG_LOCK_DATA = 8'h10;
	localparam int unsigned CMD_CODE_MSB = 2;
	localparam int unsigned CMD_IDLE_OK_BIT = 3;
	localparam int unsigned ST_BUSY_BIT = 0;
	localparam int unsigned ST_REFUSED_BIT = 1;
	localparam int unsigned ST_LOCKED_BIT = 2;
	localparam int unsigned ST_SEL_OK_BIT = 3;
	localparam int unsigned ST_WR_OK_BIT = 4;
	localparam int unsigned ST_DONE_BIT = 5;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// Command codes written to the command register.
	localparam logic [2:0] CMD_LOCK = 3'h1;
	localparam logic [2:0] CMD_UNLOCK = 3'h2;
	localparam logic [2:0] CMD_RD_LOCK = 3'h3;
	localparam logic [2:0] CMD_GLOBAL_LOCK = 3'h4;
	localparam logic [2:0] CMD_GLOBAL_UNLOCK = 3'h5;
	localparam logic [2:0] CMD_RESET = 3'h6;

	// ----------------------------------------------------------------
	// State machines
	// ----------------------------------------------------------------
	typedef enum logic [5:0] {
		S_IDLE = 6'h01,
		S_WREN = 6'h02,
		S_OP = 6'h04,
		S_RST_EN = 6'h08,
		S_RST_DO = 6'h10,
		S_RST_WAIT = 6'h20
	} fsl_state_e;

	typedef enum logic [3:0] {
		E_IDLE = 4'h1,
		E_SHIFT = 4'h2,
		E_HOLD = 4'h4,
		E_GAP = 4'h8
	} fsl_eng_e;

endpackage : fsl_pkg

// ===== logic/fsl_wait_timer.sv
// One-shot wait timer that reports when a loaded cycle count has elapsed.
`timescale 1ns/100ps
module fsl_wait_timer #(
	parameter int unsigned CYCLES = 16
) (
	// Clock and reset
	input wire logic mclk,
	input wire logic nrst,
	// Control
	input wire logic start,
	output logic expired
);
	import fsl_pkg::*;

	logic [31:0] count;
	logic running;

	// Counts down from the load; a start while running restarts the wait.
	always_ff @(posedge mclk) begin
		if (!nrst) begin
			count <= 32'h0;
			running <= 1'b0;
			expired <= 1'b0;
		end else begin
			expired <= 1'b0;
			if (start) begin
				count <= 32'(CYCLES);
				running <= 1'b1;
			end else if (running) begin
				if (count <= 32'h1) begin
					running <= 1'b0;
					expired <= 1'b1;
				end else begin
					count <= count - 32'h1;
				end
			end
		end
	end

endmodule : fsl_wait_timer

// ===== logic/fsl_spi_shift.sv
// Mode-0 serial frame engine: one chip select frame per start pulse.
`timescale 1ns/100ps
module fsl_spi_shift (
	// Clock and reset
	input wire logic mclk,
	input wire logic nrst,
	// Frame request
	input wire logic start,
	input wire logic [31:0] tx_word,
	input wire logic [5:0] n_bits,
	output logic done,
	output logic [7:0] rx_byte,
	// Serial pins
	output logic spi_sclk,
	output logic spi_cs_n,
	output logic serial_in,
	input wire logic serial_out
);
	import fsl_pkg::*;

	fsl_eng_e st;
	logic [31:0] shreg;
	logic [5:0] left;
	logic [3:0] tick;
	logic miso_q1;
	logic miso_q2;
	logic half_end;

	// Two-stage synchroniser; only the second stage feeds the receive shifter.
	always_ff @(posedge mclk) begin
		if (!nrst) begin
			miso_q1 <= 1'b0;
			miso_q2 <= 1'b0;
		end else begin
			miso_q1 <= serial_out;
			miso_q2 <= miso_q1;
		end
	end

	assign half_end = (tick == SCLK_HALF_CYC - 4'h1);

	// Half-period divider; it restarts with each frame so phases line up.
	always_ff @(posedge mclk) begin
		if (!nrst || st == E_IDLE || half_end) begin
			tick <= 4'h0;
		end else begin
			tick <= tick + 4'h1;
		end
	end

	// Data are launched while the clock is low and the reply is sampled late in
	// the high phase, well after the far end changed it on the falling edge.
	always_ff @(posedge mclk) begin
		if (!nrst) begin
			st <= E_IDLE;
			shreg <= 32'h0;
			left <= 6'h0;
			rx_byte <= 8'h0;
			done <= 1'b0;
			spi_sclk <= 1'b0;
			spi_cs_n <= 1'b1;
			serial_in <= 1'b0;
		end else begin
			done <= 1'b0;
			case (st)
				E_IDLE: begin
					if (start) begin
						spi_cs_n <= 1'b0;
						shreg <= tx_word;
						serial_in <= tx_word[31];
						left <= n_bits;
						st <= E_SHIFT;
					end
				end
				E_SHIFT: begin
					if (half_end) begin
						if (!spi_sclk) begin
							spi_sclk <= 1'b1;
						end else begin
							spi_sclk <= 1'b0;
							rx_byte <= {rx_byte[6:0], miso_q2};
							shreg <= {shreg[30:0], 1'b0};
							serial_in <= shreg[30];
							left <= left - 6'h1;
							if (left == BITS_LAST) begin
								st <= E_HOLD;
							end
						end
					end
				end
				E_HOLD: begin
					if (half_end) begin
						spi_cs_n <= 1'b1;
						serial_in <= 1'b0;
						st <= E_GAP;
					end
				end
				E_GAP: begin
					if (half_end) begin
						done <= 1'b1;
						st <= E_IDLE;
					end
				end
				default: begin
					st <= E_IDLE;
					spi_cs_n <= 1'b1;
				end
			endcase
		end
	end

endmodule : fsl_spi_shift

// ===== logic/fsl_host.sv
// Host controller issuing block lock and software reset instructions to a serial flash.
//
// Added by the designer: register access over AXI4-Lite and the placing of the registers.
`timescale 1ns/100ps
// How it works
// [RQ1] Device applies lock bits only when lock_scheme_select is 1.
// [RQ2] With lock_scheme_select 0, device uses status protect bits only.
// [RQ3] Lock bits are volatile and come up locked after power-up or reset.
// [RQ4] Single lock: opcode 36h, 24-bit address, then chip select high.
// [RQ5] Single unlock: opcode 39h, 24-bit address, then chip select high.
// [RQ6] Lock-type instructions need write_enable_latch_bit set by a prior write enable.
// [RQ7] Read lock: opcode 3Dh, 24-bit address, reply shifted out MSB first.
// [RQ8] Reply LSB 1 means locked, 0 means unlocked.
// [RQ9] Global lock: opcode 7Eh alone sets every lock bit.
// [RQ10] Global unlock: opcode 98h alone clears every lock bit.
// [RQ11] Software reset needs 66h then 99h, each as its own frame.
// [RQ12] Any other instruction after 66h cancels the reset enable.
// [RQ13] Accepted reset restores defaults and clears write_enable_latch_bit and suspend_flag.
// [RQ14] After a reset, nothing is sent for about 30 microseconds.
// [RQ15] Busy and suspend_flag should be checked clear before the reset pair.
// [RQ16] Wait 20 us before chip select and 5 ms before writes.
// [RQ17] Device maps every 24-bit address to exactly one lock bit.
module fsl_host #(
	parameter int unsigned PUW_CYC = fsl_pkg::PUW_CYC_DEF,
	parameter int unsigned RST_CYC = fsl_pkg::RST_CYC_DEF
) (
	// Clock and reset
	input wire logic mclk,
	input wire logic nrst,
	// AXI4-Lite write channels
	input wire logic [fsl_pkg::AXI_AW-1:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	// AXI4-Lite read channels
	input wire logic [fsl_pkg::AXI_AW-1:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// Flash serial pins
	output logic spi_sclk,
	output logic spi_cs_n,
	output logic serial_in,
	input wire logic serial_out
);
	import fsl_pkg::*;

	// ----------------------------------------------------------------
	// Declarations
	// ----------------------------------------------------------------
	fsl_state_e state;
	logic [AXI_AW-1:0] aw_addr;
	logic aw_got;
	logic [31:0] w_data;
	logic [3:0] w_strb;
	logic w_got;
	logic do_write;
	logic wr_hit;
	logic [31:0] rd_mux;
	logic rd_hit;
	logic [23:0] addr_reg;
	logic [7:0] wren_op;
	logic [2:0] cmd_code;
	logic [7:0] lock_data;
	logic refused;
	logic cmd_done;
	logic [31:0] pu_cnt;
	logic sel_ok;
	logic wr_ok;
	logic eng_start;
	logic [31:0] eng_tx;
	logic [5:0] eng_bits;
	logic eng_done;
	logic [7:0] eng_rx;
	logic tmr_start;
	logic tmr_expired;
	logic [2:0] wr_code;
	logic wr_idle_ok;
	logic code_ok;
	logic code_write;
	logic accept;
	logic [7:0] next_opcode;
	logic [5:0] next_bits;
	logic next_has_addr;
	logic [31:0] status_word;
	logic [31:0] addr_merged;

	// Merges written bytes under their strobes into the old word.
	function automatic logic [31:0] fsl_merge(input logic [31:0] old_w, input logic [31:0] new_w,
		input logic [3:0] strb);
		logic [31:0] res;
		res = old_w;
		for (int i = 0; i < 4; i++) begin
			if (strb[i]) begin
				res[i*8 +: 8] = new_w[i*8 +: 8];
			end
		end
		return res;
	endfunction : fsl_merge

	// ----------------------------------------------------------------
	// AXI4-Lite slave
	// ----------------------------------------------------------------
	assign do_write = aw_got && w_got && !s_axi_bvalid;

	// Address and data are caught independently, so either may come first.
	always_ff @(posedge mclk) begin
		if (!nrst) begin
			s_axi_awready <= 1'b0;
			aw_got <= 1'b0;
			aw_addr <= '0;
		end else if (s_axi_awready && s_axi_awvalid) begin
			s_axi_awready <= 1'b0;
			aw_got <= 1'b1;
			aw_addr <= s_axi_awaddr;
		end else if (do_write) begin
			aw_got <= 1'b0;
		end else if (!aw_got && !s_axi_bvalid) begin
			s_axi_awready <= 1'b1;
		end
	end

	always_ff @(posedge mclk) begin
		if (!nrst) begin
			s_axi_wready <= 1'b0;
			w_got <= 1'b0;
			w_data <= 32'h0;
			w_strb <= 4'h0;
		end else if (s_axi_wready && s_axi_wvalid) begin
			s_axi_wready <= 1'b0;
			w_got <= 1'b1;
			w_data <= s_axi_wdata;
			w_strb <= s_axi_wstrb;
		end else if (do_write) begin
			w_got <= 1'b0;
		end else if (!w_got && !s_axi_bvalid) begin
			s_axi_wready <= 1'b1;
		end
	end

	assign wr_hit = ({aw_addr[AXI_AW-1:2], 2'b00} == REG_CMD) ||
		({aw_addr[AXI_AW-1:2], 2'b00} == REG_ADDR) ||
		({aw_addr[AXI_AW-1:2], 2'b00} == REG_STATUS) ||
		({aw_addr[AXI_AW-1:2], 2'b00} == REG_WREN_OP) ||
		({aw_addr[AXI_AW-1:2], 2'b00} == REG_LOCK_DATA);

	// Write response one cycle after both halves are held; unmapped gets an error.
	always_ff @(posedge mclk) begin
		if (!nrst) begin
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= RESP_OKAY;
		end else if (do_write) begin
			s_axi_bvalid <= 1'b1;
			s_axi_bresp <= wr_hit ? RESP_OKAY : RESP_SLVERR;
		end else if (s_axi_bready) begin
			s_axi_bvalid <= 1'b0;
		end
	end

	// Read mux; status and lock data are read-only views of block state.
	always_comb begin
		rd_mux = 32'h0;
		rd_hit = 1'b1;
		case ({s_axi_araddr[AXI_AW-1:2], 2'b00})
			REG_CMD: rd_mux = {29'h0, cmd_code};
			REG_ADDR: rd_mux = {8'h0, addr_reg};
			REG_STATUS: rd_mux = status_word;
			REG_WREN_OP: rd_mux = {24'h0, wren_op};
			REG_LOCK_DATA: rd_mux = {24'h0, lock_data};
			default: rd_hit = 1'b0;
		endcase
	end

	always_ff @(posedge mclk) begin
		if (!nrst) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h0;
			s_axi_rresp <= RESP_OKAY;
		end else if (s_axi_arready && s_axi_arvalid) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b1;
			s_axi_rdata <= rd_mux;
			s_axi_rresp <= rd_hit ? RESP_OKAY : RESP_SLVERR;
		end else if (s_axi_rvalid && s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
		end else if (!s_axi_rvalid) begin
			s_axi_arready <= 1'b1;
		end
	end

	// ----------------------------------------------------------------
	// Command decode and acceptance
	// ----------------------------------------------------------------
	assign wr_code = w_data[CMD_CODE_MSB:0];
	assign wr_idle_ok = w_data[CMD_IDLE_OK_BIT];

	always_comb begin
		next_opcode = OP_RD_LOCK;
		next_bits = BITS_RD_LOCK;
		next_has_addr = 1'b1;
		code_ok = 1'b1;
		code_write = 1'b1;
		case (wr_code)
			CMD_LOCK: begin
				next_opcode = OP_LOCK;
				next_bits = BITS_OP_ADDR;
			end
			CMD_UNLOCK: begin
				next_opcode = OP_UNLOCK;
				next_bits = BITS_OP_ADDR;
			end
			CMD_RD_LOCK: code_write = 1'b0;
			CMD_GLOBAL_LOCK: begin
				next_opcode = OP_GLOBAL_LOCK;
				next_bits = BITS_OPCODE;
				next_has_addr = 1'b0;
			end
			CMD_GLOBAL_UNLOCK: begin
				next_opcode = OP_GLOBAL_UNLOCK;
				next_bits = BITS_OPCODE;
				next_has_addr = 1'b0;
			end
			CMD_RESET: begin
				next_opcode = OP_RESET_EN;
				next_bits = BITS_OPCODE;
				next_has_addr = 1'b0;
				code_write = 1'b0;
			end
			default: code_ok = 1'b0;
		endcase
	end

	// [RQ15] Reset needs confirmation. Software sets the idle bit once it has seen
	// busy and suspend_flag clear; the host cannot know that on its own.
	// [RQ16] Power-up gating. No frame before the select delay, no write before the write delay.
	assign accept = do_write && w_strb[0] && ({aw_addr[AXI_AW-1:2], 2'b00} == REG_CMD) &&
		state == S_IDLE && code_ok && sel_ok && (wr_ok || !code_write) &&
		(wr_idle_ok || wr_code != CMD_RESET);

	// A function result cannot be sliced directly, so the merged word is a net first.
	assign addr_merged = fsl_merge({8'h0, addr_reg}, w_data, w_strb);

	// Software registers: address, write enable opcode and last accepted command code.
	always_ff @(posedge mclk) begin
		if (!nrst) begin
			addr_reg <= 24'h0;
			wren_op <= 8'h0;
			cmd_code <= 3'h0;
		end else if (do_write) begin
			if ({aw_addr[AXI_AW-1:2], 2'b00} == REG_ADDR) begin
				addr_reg <= addr_merged[23:0];
			end
			if ({aw_addr[AXI_AW-1:2], 2'b00} == REG_WREN_OP && w_strb[0]) begin
				wren_op <= w_data[7:0];
			end
			if (accept) begin
				cmd_code <= wr_code;
			end
		end
	end

	// Refused flag stays until the next accepted command; every accept also meets the refusal condition, and accept wins.
	always_ff @(posedge mclk) begin
		if (!nrst) begin
			refused <= 1'b0;
		end else if (accept) begin
			refused <= 1'b0;
		end else if (do_write && w_strb[0] && {aw_addr[AXI_AW-1:2], 2'b00} == REG_CMD) begin
			refused <= 1'b1;
		end
	end

	// [RQ16] Power-up counter. Saturates once the longer write delay has passed.
	always_ff @(posedge mclk) begin
		if (!nrst) begin
			pu_cnt <= 32'h0;
			sel_ok <= 1'b0;
			wr_ok <= 1'b0;
		end else begin
			if (pu_cnt < 32'(PUW_CYC)) begin
				pu_cnt <= pu_cnt + 32'h1;
			end
			sel_ok <= (pu_cnt >= 32'(VSL_CYC));
			wr_ok <= (pu_cnt >= 32'(PUW_CYC));
		end
	end

	// ----------------------------------------------------------------
	// Sequencer
	// ----------------------------------------------------------------
	always_ff @(posedge mclk) begin
		if (!nrst) begin
			state <= S_IDLE;
			eng_start <= 1'b0;
			eng_tx <= 32'h0;
			eng_bits <= BITS_OPCODE;
			tmr_start <= 1'b0;
			lock_data <= 8'h0;
			cmd_done <= 1'b0;
		end else begin
			eng_start <= 1'b0;
			tmr_start <= 1'b0;
			case (state)
				S_IDLE: begin
					if (accept) begin
						cmd_done <= 1'b0;
						eng_start <= 1'b1;
						// [RQ6] Write enable first. Each lock-type frame follows its own write enable.
						if (code_write) begin
							eng_tx <= {wren_op, 24'h0};
							eng_bits <= BITS_OPCODE;
							state <= S_WREN;
						end else begin
							// [RQ7] Read lock frame.
							// [RQ11] Reset enable frame. Sent alone, then the reset frame follows.
							eng_tx <= {next_opcode, next_has_addr ? addr_reg : 24'h0};
							eng_bits <= next_bits;
							state <= (wr_code == CMD_RESET) ? S_RST_EN : S_OP;
						end
					end
				end
				S_WREN: begin
					if (eng_done) begin
						// [RQ4] Lock address frame. Opcode, 24-bit address, then select rises.
						// [RQ9] Global frames. Opcode alone, no address.
						// [RQ5] Unlock address frame.
						// [RQ10] Global unlock frame.
						eng_start <= 1'b1;
						eng_tx <= {next_opcode, next_has_addr ? addr_reg : 24'h0};
						eng_bits <= next_bits;
						state <= S_OP;
					end
				end
				S_OP: begin
					if (eng_done) begin
						// [RQ8] Lock reply byte. Its low bit is the locked state.
						if (cmd_code == CMD_RD_LOCK) begin
							lock_data <= eng_rx;
						end
						cmd_done <= 1'b1;
						state <= S_IDLE;
					end
				end
				S_RST_EN: begin
					if (eng_done) begin
						// [RQ12] Reset follows directly. Nothing may slip between the pair.
						eng_start <= 1'b1;
						eng_tx <= {OP_RESET, 24'h0};
						eng_bits <= BITS_OPCODE;
						state <= S_RST_DO;
					end
				end
				S_RST_DO: begin
					if (eng_done) begin
						tmr_start <= 1'b1;
						state <= S_RST_WAIT;
					end
				end
				S_RST_WAIT: begin
					// [RQ14] Recovery wait. Busy holds off commands until it ends.
					if (tmr_expired) begin
						cmd_done <= 1'b1;
						state <= S_IDLE;
					end
				end
				default: state <= S_IDLE;
			endcase
		end
	end

	always_comb begin
		status_word = 32'h0;
		status_word[ST_BUSY_BIT] = (state != S_IDLE);
		status_word[ST_REFUSED_BIT] = refused;
		status_word[ST_LOCKED_BIT] = lock_data[0];
		status_word[ST_SEL_OK_BIT] = sel_ok;
		status_word[ST_WR_OK_BIT] = wr_ok;
		status_word[ST_DONE_BIT] = cmd_done;
	end

	// ----------------------------------------------------------------
	// Submodules
	// ----------------------------------------------------------------
	fsl_spi_shift u_shift (
		.mclk(mclk),
		.nrst(nrst),
		.start(eng_start),
		.tx_word(eng_tx),
		.n_bits(eng_bits),
		.done(eng_done),
		.rx_byte(eng_rx),
		.spi_sclk(spi_sclk),
		.spi_cs_n(spi_cs_n),
		.serial_in(serial_in),
		.serial_out(serial_out)
	);

	fsl_wait_timer #(
		.CYCLES(RST_CYC)
	) u_rst_wait (
		.mclk(mclk),
		.nrst(nrst),
		.start(tmr_start),
		.expired(tmr_expired)
	);

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	logic [7:0] last_op;
	logic wren_sent;
	logic rst_seen;
	logic [31:0] since_rst;

	always_ff @(posedge mclk) begin
		if (!nrst) begin
			last_op <= 8'h0;
			wren_sent <= 1'b0;
			rst_seen <= 1'b0;
			since_rst <= 32'h0;
		end else begin
			if (eng_start) begin
				last_op <= eng_tx[31:24];
			end
			if (state == S_WREN && eng_done) begin
				wren_sent <= 1'b1;
			end else if (eng_start) begin
				wren_sent <= 1'b0;
			end
			if (state == S_RST_DO && eng_done) begin
				rst_seen <= 1'b1;
				since_rst <= 32'h0;
			end else if (since_rst < 32'(RST_CYC)) begin
				since_rst <= since_rst + 32'h1;
			end
		end
	end

	a_lock_frame: assert property (@(posedge mclk) disable iff (!nrst) // [RQ4]
		eng_start && eng_tx[31:24] == OP_LOCK |-> eng_bits == BITS_OP_ADDR && eng_tx[23:0] == addr_reg)
		else $error("lock frame not opcode plus address");
	a_unlock_frame: assert property (@(posedge mclk) disable iff (!nrst) // [RQ5]
		eng_start && eng_tx[31:24] == OP_UNLOCK |-> eng_bits == BITS_OP_ADDR ##1 !spi_cs_n)
		else $error("unlock frame malformed");
	a_wren_first: assert property (@(posedge mclk) disable iff (!nrst) // [RQ6]
		eng_start && (eng_tx[31:24] == OP_LOCK || eng_tx[31:24] == OP_GLOBAL_UNLOCK ||
		eng_tx[31:24] == OP_UNLOCK || eng_tx[31:24] == OP_GLOBAL_LOCK) |-> wren_sent)
		else $error("lock-type frame without write enable");
	a_read_len: assert property (@(posedge mclk) disable iff (!nrst) // [RQ7]
		eng_start && eng_tx[31:24] == OP_RD_LOCK |-> eng_bits == BITS_RD_LOCK)
		else $error("read lock frame length wrong");
	a_global_len: assert property (@(posedge mclk) disable iff (!nrst) // [RQ10]
		eng_start && (eng_tx[31:24] == OP_GLOBAL_LOCK || eng_tx[31:24] == OP_GLOBAL_UNLOCK)
		|-> eng_bits == BITS_OPCODE)
		else $error("global frame carries address");
	a_reset_pair: assert property (@(posedge mclk) disable iff (!nrst) // [RQ11]
		eng_start && eng_tx[31:24] == OP_RESET |-> last_op == OP_RESET_EN && $past(state) == S_RST_EN)
		else $error("reset not directly after reset enable");
	a_reset_quiet: assert property (@(posedge mclk) disable iff (!nrst) // [RQ14]
		eng_start && rst_seen |-> since_rst >= 32'(RST_CYC))
		else $error("frame sent during reset recovery");
	a_select_delay: assert property (@(posedge mclk) disable iff (!nrst) // [RQ16]
		$fell(spi_cs_n) |-> pu_cnt >= 32'(VSL_CYC))
		else $error("chip select before power-up select delay");
	a_write_delay: assert property (@(posedge mclk) disable iff (!nrst) // [RQ16]
		eng_start && state == S_WREN |-> wr_ok)
		else $error("write enable before power-up write delay");
	a_lock_capture: assert property (@(posedge mclk) disable iff (!nrst) // [RQ8]
		state == S_OP && eng_done && cmd_code == CMD_RD_LOCK |=> lock_data == $past(eng_rx))
		else $error("lock reply not captured");

endmodule : fsl_host

// ===== tb/fsl_flash_model.sv
// Behavioural serial flash that keeps the volatile block lock bits.
`timescale 1ns/100ps
module fsl_flash_model #(
	parameter logic [7:0] WREN_CODE = 8'h06,
	parameter int RST_NS = 200
) (
	// Serial pins
	input wire logic spi_sclk,
	input wire logic spi_cs_n,
	input wire logic serial_in,
	output logic serial_out = 1'b0
);
	// ----
	// Lock state
	// ----
	// The model keeps lock_scheme_select at 1, so these bits guard the array.
	logic [15:0] lock = '1;
	logic write_enable_latch_bit = 1'b0;
	logic rst_en = 1'b0;
	logic [31:0] sh;
	logic [5:0] n;
	logic [7:0] op;
	logic [3:0] adr;
	logic [7:0] code;
	time ready_t = 0;
	// Each frame restarts the bit count.
	always @(negedge spi_cs_n) begin
		n = 6'h00;
	end
	// Address bits 23 to 20 pick one of sixteen lock bits.
	always @(posedge spi_sclk) begin
		if (!spi_cs_n) begin
			sh = {sh[30:0], serial_in};
			n = n + 6'h01;
			if (n == 6'h20) begin
				op = sh[31:24];
				adr = sh[23:20];
			end
		end
	end
	// The reply byte goes out MSB first, with the lock state in its LSB.
	// Outside the reply the line toggles, so a stale level never passes.
	always @(negedge spi_sclk) begin
		if (!spi_cs_n && n >= 6'h20 && op == 8'h3d && $time >= ready_t)
			serial_out = (n == 6'h27) ? lock[adr] : 1'b0;
		else
			serial_out = ~serial_out;
	end
	// Instructions act when chip select rises.
	always @(posedge spi_cs_n) begin
		serial_out = ~serial_out;
		code = (n == 6'h08) ? sh[7:0] : op;
		// Frames that arrive during reset recovery are dropped.
		if ($time >= ready_t && n != 6'h00) begin
			// Lock instructions need the write enable latch; the reset relock does not.
			case (code)
				8'h36: if (write_enable_latch_bit && n == 6'h20) lock[adr] = 1'b1;
				8'h39: if (write_enable_latch_bit && n == 6'h20) lock[adr] = 1'b0;
				8'h7e: if (write_enable_latch_bit && n == 6'h08) lock = '1;
				8'h98: if (write_enable_latch_bit && n == 6'h08) lock = '0;
				// An accepted reset relocks every block.
				8'h99: if (rst_en && n == 6'h08) begin
					lock = '1;
					ready_t = $time + RST_NS;
				end
				default: ;
			endcase
			// Any other frame clears both latches, except that a read lock frame (3Dh) keeps the write enable latch.
			write_enable_latch_bit = (n == 6'h08 && code == WREN_CODE) || (write_enable_latch_bit && code == 8'h3d);
			rst_en = (n == 6'h08 && code == 8'h66);
		end
	end
endmodule : fsl_flash_model

// ===== tb/testbench.sv
// Self-checking bench for the flash sector lock host controller.
`timescale 1ns/100ps
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin n_mismatch++; \
	$display("CHECK FAILED %s expected %h seen %h", nm, e, g); end end
module testbench;
	import fsl_pkg::*;
	// ----
	// Signals and parts
	// ----
	localparam logic [7:0] WREN = 8'h06;
	logic mclk = 0;
	logic nrst = 0;
	logic [7:0] aa = '0;
	logic [7:0] ra = '0;
	logic [31:0] wd = '0;
	logic [3:0] ws = 4'hf;
	logic av = 0, wv = 0, br = 0, rv = 0, rr = 0;
	logic ar, wrd, bv, arr, rvl, sclk, cs_n, si, so;
	logic [1:0] bresp, rresp, r;
	logic [31:0] rdata, d;
	int n_mismatch = 0, n_checks = 0, cyc = 0;
	always #2.5 mclk = ~mclk;
	fsl_host #(.PUW_CYC(5000), .RST_CYC(50)) dut (.mclk(mclk), .nrst(nrst),
		.s_axi_awaddr(aa), .s_axi_awvalid(av), .s_axi_awready(ar), .s_axi_wdata(wd),
		.s_axi_wstrb(ws), .s_axi_wvalid(wv), .s_axi_wready(wrd), .s_axi_bresp(bresp),
		.s_axi_bvalid(bv), .s_axi_bready(br), .s_axi_araddr(ra), .s_axi_arvalid(rv),
		.s_axi_arready(arr), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvl),
		.s_axi_rready(rr), .spi_sclk(sclk), .spi_cs_n(cs_n), .serial_in(si), .serial_out(so));
	fsl_flash_model #(.WREN_CODE(WREN)) flash (.spi_sclk(sclk), .spi_cs_n(cs_n),
		.serial_in(si), .serial_out(so));
	// ----
	// Bus tasks
	// ----
	task automatic wr(input logic [7:0] a, input logic [31:0] v);
		logic pa;
		logic pw;
		@(posedge mclk);
		aa <= a;
		wd <= v;
		av <= 1;
		wv <= 1;
		br <= 1;
		pa = 1;
		pw = 1;
		while (pa || pw) begin
			@(posedge mclk);
			if (ar) begin
				pa = 0;
				av <= 0;
			end
			if (wrd) begin
				pw = 0;
				wv <= 0;
			end
		end
		while (!bv) @(posedge mclk);
		r = bresp;
		br <= 0;
	endtask : wr
	task automatic rd(input logic [7:0] a);
		@(posedge mclk);
		ra <= a;
		rv <= 1;
		rr <= 1;
		do @(posedge mclk); while (!arr);
		rv <= 0;
		do @(posedge mclk); while (!rvl);
		d = rdata;
		r = rresp;
		rr <= 0;
	endtask : rd
	// Polls until the command ends or is refused; leaves the status in d.
	task automatic cmd(input logic i, input logic [2:0] c);
		wr(REG_CMD, {28'h0, i, c});
		do rd(REG_STATUS);
		while (d[ST_BUSY_BIT] !== 1'b0 || (d[ST_DONE_BIT] !== 1'b1 && d[ST_REFUSED_BIT] !== 1'b1));
	endtask : cmd
	task automatic see(input logic [7:0] e);
		cmd(1'b0, CMD_RD_LOCK);
		`CHK("done flag", 1'b1, d[ST_DONE_BIT])
		`CHK("locked flag", e[0], d[ST_LOCKED_BIT])
		rd(REG_LOCK_DATA);
		`CHK("lock reply", e, d[7:0])
	endtask : see
	task automatic give_verdict();
		$display("checks %0d mismatches %0d", n_checks, n_mismatch);
		if (n_mismatch == 0 && n_checks > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask : give_verdict
	// A hang is cut short well beyond the expected run length.
	always @(posedge mclk) begin
		cyc++;
		if (cyc == 60000) begin
			n_mismatch++;
			give_verdict();
		end
	end
	// Main sequence.
	initial begin
		repeat (6) @(posedge mclk);
		nrst <= 1;
		rd(REG_STATUS);
		`CHK("power-up gates", 2'h0, d[ST_WR_OK_BIT:ST_SEL_OK_BIT])
		cmd(1'b0, CMD_GLOBAL_LOCK);
		`CHK("early refusal", 1'b1, d[ST_REFUSED_BIT])
		do rd(REG_STATUS); while (d[ST_SEL_OK_BIT] !== 1'b1);
		see(8'h01);
		// The read above cleared the refused flag, so this refusal is fresh.
		cmd(1'b0, CMD_GLOBAL_LOCK);
		`CHK("write delay refusal", 1'b1, d[ST_REFUSED_BIT])
		see(8'h01);
		cmd(1'b0, 3'h7);
		`CHK("bad code refusal", 1'b1, d[ST_REFUSED_BIT])
		wr(8'h20, 32'h0);
		`CHK("unmapped write", RESP_SLVERR, r)
		rd(8'h20);
		`CHK("unmapped read", RESP_SLVERR, r)
		do rd(REG_STATUS); while (d[ST_WR_OK_BIT] !== 1'b1);
		wr(REG_ADDR, 32'h0035_0000);
		see(8'h01);
		cmd(1'b0, CMD_UNLOCK);
		see(8'h01);
		wr(REG_WREN_OP, {24'h0, WREN});
		cmd(1'b0, CMD_UNLOCK);
		see(8'h00);
		wr(REG_ADDR, 32'h0045_0000);
		see(8'h01);
		wr(REG_ADDR, 32'h0035_0000);
		cmd(1'b0, CMD_LOCK);
		see(8'h01);
		cmd(1'b0, CMD_GLOBAL_UNLOCK);
		see(8'h00);
		cmd(1'b0, CMD_GLOBAL_LOCK);
		see(8'h01);
		cmd(1'b0, CMD_GLOBAL_UNLOCK);
		cmd(1'b0, CMD_RESET);
		`CHK("unconfirmed reset", 1'b1, d[ST_REFUSED_BIT])
		cmd(1'b1, CMD_RESET);
		see(8'h01);
		give_verdict();
	end
endmodule : testbench
